/* hdl/psa_defs.vh */
`ifndef PSA_DEFS_VH
`define PSA_DEFS_VH
// Function
// RQ1: opcode 0F67 packs operand words into bytes with unsigned saturation.
// RQ2: opcode 0FFC adds eight byte lanes with wrap-around.
// RQ3: opcode 0FFE adds two doubleword lanes with wrap-around.
// RQ4: opcode 0FEC adds eight signed byte lanes with signed saturation.
// RQ5: opcode 0FED adds four signed word lanes with signed saturation.
// RQ6: opcode 0FDC adds eight unsigned byte lanes with unsigned saturation.
// RQ7: opcode 0FDD adds four unsigned word lanes with unsigned saturation.
// RQ8: opcode 0FFD adds four word lanes with wrap-around.
// RQ9: opcode 0FDB writes 64-bit bitwise AND of destination and source.
// RQ10: opcode 0FDF writes 64-bit AND-NOT of destination and source.
// RQ11: opcode 0F74 byte equality compare gives all-ones or zero lanes.
// RQ12: opcode 0F75 word equality compare gives all-ones or zero lanes.
// RQ13: opcode 0F76 doubleword equality compare gives all-ones or zero lanes.
// RQ14: opcode 0F64 byte greater-than compare, destination over source.
// RQ15: register source when mode field is 11, else memory, same timing.
// RQ16: pack puts destination words in low bytes, source words in high.
// RQ17: saturation replaces out-of-range lane results with the nearest bound.
// RQ18: signed lanes use the lane's most significant bit as sign.
// RQ19: AND-NOT complements destination first; greater-than compare is signed.
// RQ20: byte bounds -128..127 and 0..255; words use 16-bit bounds.

`define PSA_OP_PACK_WB_US 16'h0F67
`define PSA_OP_ADD_B      16'h0FFC
`define PSA_OP_ADD_D      16'h0FFE
`define PSA_OP_ADD_SB     16'h0FEC
`define PSA_OP_ADD_SW     16'h0FED
`define PSA_OP_ADD_UB     16'h0FDC
`define PSA_OP_ADD_UW     16'h0FDD
`define PSA_OP_ADD_W      16'h0FFD
`define PSA_OP_AND        16'h0FDB
`define PSA_OP_ANDN       16'h0FDF
`define PSA_OP_CEQ_B      16'h0F74
`define PSA_OP_CEQ_W      16'h0F75
`define PSA_OP_CEQ_D      16'h0F76
`define PSA_OP_CGT_B      16'h0F64

`define PSA_MOD_REG       2'b11
`define PSA_LATENCY       1
`define PSA_RESET_RESULT  64'h0000_0000_0000_0000

// lane size codes for the adder and compare units
`define PSA_SZ_B          2'h0
`define PSA_SZ_W          2'h1
`define PSA_SZ_D          2'h2
// add mode codes
`define PSA_AM_WRAP       2'h0
`define PSA_AM_SSAT       2'h1
`define PSA_AM_USAT       2'h2
`endif

/* hdl/psa_lane_add.v */
`include "psa_defs.vh"
module psa_lane_add #(
    parameter W = 64
) (
    // operands
    input  wire [W-1:0] dst,
    input  wire [W-1:0] src,
    // control
    input  wire [1:0]   size,
    input  wire [1:0]   mode,
    // result
    output reg  [W-1:0] sum
);
    reg [8:0]  bs;
    reg [16:0] ws;
    reg [32:0] dsum;
    integer i;
    always @* begin
        sum = {W{1'b0}};
        bs = 9'h000;
        ws = 17'h0_0000;
        dsum = 33'h0_0000_0000;
        if (size == `PSA_SZ_B) begin
            for (i = 0; i < W/8; i = i + 1) begin
                bs = {1'b0, dst[i*8 +: 8]} + {1'b0, src[i*8 +: 8]};
                sum[i*8 +: 8] = bs[7:0]; // [RQ2]
                if (mode == `PSA_AM_USAT && bs[8])
                    sum[i*8 +: 8] = 8'hFF; // [RQ6] [RQ17] [RQ20]
                // sign overflow: equal operand signs differ from result
                if (mode == `PSA_AM_SSAT &&
                    dst[i*8+7] == src[i*8+7] && bs[7] != dst[i*8+7])
                    sum[i*8 +: 8] = dst[i*8+7] ? 8'h80
                                               : 8'h7F; // [RQ4] [RQ18] [RQ20]
            end
        end else if (size == `PSA_SZ_W) begin
            for (i = 0; i < W/16; i = i + 1) begin
                ws = {1'b0, dst[i*16 +: 16]} + {1'b0, src[i*16 +: 16]};
                sum[i*16 +: 16] = ws[15:0]; // [RQ8]
                if (mode == `PSA_AM_USAT && ws[16])
                    sum[i*16 +: 16] = 16'hFFFF; // [RQ7] [RQ17] [RQ20]
                if (mode == `PSA_AM_SSAT &&
                    dst[i*16+15] == src[i*16+15] &&
                    ws[15] != dst[i*16+15])
                    sum[i*16 +: 16] = dst[i*16+15] ? 16'h8000
                                                   : 16'h7FFF; // [RQ5] [RQ18]
            end
        end else begin
            for (i = 0; i < W/32; i = i + 1) begin
                dsum = {1'b0, dst[i*32 +: 32]} + {1'b0, src[i*32 +: 32]};
                sum[i*32 +: 32] = dsum[31:0]; // [RQ3]
            end
        end
    end
endmodule

/* hdl/psa_lane_cmp.v */
`include "psa_defs.vh"
module psa_lane_cmp #(
    parameter W = 64
) (
    // operands
    input  wire [W-1:0] dst,
    input  wire [W-1:0] src,
    // control
    input  wire [1:0]   size,
    input  wire         greater,
    // mask result
    output reg  [W-1:0] mask
);
    integer i;
    always @* begin
        mask = {W{1'b0}};
        if (greater) begin
            for (i = 0; i < W/8; i = i + 1)
                if ($signed(dst[i*8 +: 8]) > $signed(src[i*8 +: 8]))
                    mask[i*8 +: 8] = 8'hFF; // [RQ14] [RQ19] [RQ18]
        end else if (size == `PSA_SZ_B) begin
            for (i = 0; i < W/8; i = i + 1)
                if (dst[i*8 +: 8] == src[i*8 +: 8])
                    mask[i*8 +: 8] = 8'hFF; // [RQ11]
        end else if (size == `PSA_SZ_W) begin
            for (i = 0; i < W/16; i = i + 1)
                if (dst[i*16 +: 16] == src[i*16 +: 16])
                    mask[i*16 +: 16] = 16'hFFFF; // [RQ12]
        end else begin
            for (i = 0; i < W/32; i = i + 1)
                if (dst[i*32 +: 32] == src[i*32 +: 32])
                    mask[i*32 +: 32] = 32'hFFFF_FFFF; // [RQ13]
        end
    end
endmodule

/* hdl/psa_simd_unit.v */
`include "psa_defs.vh"
module psa_simd_unit #(
    parameter W = 64
) (
    // clock and reset
    input  wire         sys_clk,
    input  wire         rst_n,
    // issue
    input  wire         issue_valid,
    input  wire [15:0]  opcode,
    input  wire [1:0]   modrm_mode,
    input  wire [2:0]   dest_index,
    // operands
    input  wire [W-1:0] dest_vector_reg,
    input  wire [W-1:0] src_vector_reg,
    input  wire [W-1:0] mem_operand,
    // result
    output reg          result_valid,
    output reg          result_illegal,
    output reg  [2:0]   result_index,
    output reg  [W-1:0] result_data
);
    ////////////////////////////////////////////////////////////////////////
    // operand selection and decode
    wire [W-1:0] src_sel;
    reg  [1:0]   add_size;
    reg  [1:0]   add_mode;
    reg  [1:0]   cmp_size;
    reg          cmp_gt;
    reg  [2:0]   cls;
    reg          known;
    wire [W-1:0] add_out;
    wire [W-1:0] cmp_out;
    reg  [W-1:0] pack_out;
    reg  [W-1:0] result_next;
    integer      k;

    localparam CLS_ADD  = 3'h0;
    localparam CLS_CMP  = 3'h1;
    localparam CLS_AND  = 3'h2;
    localparam CLS_ANDN = 3'h3;
    localparam CLS_PACK = 3'h4;

    // same path and timing for register and memory sources
    assign src_sel = (modrm_mode == `PSA_MOD_REG) ?
                     src_vector_reg : mem_operand; // [RQ15]

    function [7:0] sat_u8;
        input [15:0] w;
        begin
            if (w[15])
                sat_u8 = 8'h00; // [RQ17] [RQ18]
            else if (w[14:8] != 7'h00)
                sat_u8 = 8'hFF; // [RQ20]
            else
                sat_u8 = w[7:0];
        end
    endfunction

    always @* begin
        add_size = `PSA_SZ_B;
        add_mode = `PSA_AM_WRAP;
        cmp_size = `PSA_SZ_B;
        cmp_gt   = 1'b0;
        cls      = CLS_ADD;
        known    = 1'b1;
        case (opcode)
            `PSA_OP_ADD_B:  add_size = `PSA_SZ_B; // [RQ2]
            `PSA_OP_ADD_W:  add_size = `PSA_SZ_W; // [RQ8]
            `PSA_OP_ADD_D:  add_size = `PSA_SZ_D; // [RQ3]
            `PSA_OP_ADD_SB: add_mode = `PSA_AM_SSAT; // [RQ4]
            `PSA_OP_ADD_UB: add_mode = `PSA_AM_USAT; // [RQ6]
            `PSA_OP_ADD_SW: begin
                add_size = `PSA_SZ_W; // [RQ5]
                add_mode = `PSA_AM_SSAT;
            end
            `PSA_OP_ADD_UW: begin
                add_size = `PSA_SZ_W; // [RQ7]
                add_mode = `PSA_AM_USAT;
            end
            `PSA_OP_AND:    cls = CLS_AND; // [RQ9]
            `PSA_OP_ANDN:   cls = CLS_ANDN; // [RQ10]
            `PSA_OP_PACK_WB_US: cls = CLS_PACK; // [RQ1]
            `PSA_OP_CEQ_B:  cls = CLS_CMP; // [RQ11]
            `PSA_OP_CEQ_W: begin
                cls = CLS_CMP; // [RQ12]
                cmp_size = `PSA_SZ_W;
            end
            `PSA_OP_CEQ_D: begin
                cls = CLS_CMP; // [RQ13]
                cmp_size = `PSA_SZ_D;
            end
            `PSA_OP_CGT_B: begin
                cls = CLS_CMP; // [RQ14]
                cmp_gt = 1'b1;
            end
            default: known = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // lane units
    psa_lane_add #(
        .W (W)
    ) u_add (
        .dst  (dest_vector_reg),
        .src  (src_sel),
        .size (add_size),
        .mode (add_mode),
        .sum  (add_out)
    );

    psa_lane_cmp #(
        .W (W)
    ) u_cmp (
        .dst     (dest_vector_reg),
        .src     (src_sel),
        .size    (cmp_size),
        .greater (cmp_gt),
        .mask    (cmp_out)
    );

    // destination words fill the low half, source words the high half
    always @* begin
        pack_out = {W{1'b0}};
        for (k = 0; k < W/16; k = k + 1) begin
            pack_out[k*8 +: 8] = sat_u8(dest_vector_reg[k*16 +: 16]); // [RQ16]
            pack_out[W/2 + k*8 +: 8] = sat_u8(src_sel[k*16 +: 16]); // [RQ1]
        end
    end

    always @* begin
        case (cls)
            CLS_ADD:  result_next = add_out;
            CLS_CMP:  result_next = cmp_out;
            CLS_AND:  result_next = dest_vector_reg & src_sel; // [RQ9]
            CLS_ANDN: result_next = ~dest_vector_reg & src_sel; // [RQ10] [RQ19]
            CLS_PACK: result_next = pack_out;
            default:  result_next = {W{1'b0}};
        endcase
        if (!known)
            result_next = {W{1'b0}};
    end

    ////////////////////////////////////////////////////////////////////////
    // single-cycle result register, one issue per clock
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            result_valid   <= 1'b0;
            result_illegal <= 1'b0;
            result_index   <= 3'h0;
            result_data    <= `PSA_RESET_RESULT;
        end else begin
            result_valid   <= issue_valid & known; // [RQ15]
            result_illegal <= issue_valid & ~known;
            if (issue_valid) begin
                result_index <= dest_index;
                result_data  <= result_next;
            end
        end
    end
endmodule

/* dv/psa_simd_unit_asserts.sv */
module psa_simd_unit_asserts #(
    parameter W = 64
) (
    // clock and reset
    input wire         sys_clk,
    input wire         rst_n,
    // issue
    input wire         issue_valid,
    input wire [15:0]  opcode,
    input wire [1:0]   modrm_mode,
    input wire [2:0]   dest_index,
    // operands
    input wire [W-1:0] dest_vector_reg,
    input wire [W-1:0] src_vector_reg,
    input wire [W-1:0] mem_operand,
    // result
    input wire         result_valid,
    input wire         result_illegal,
    input wire [2:0]   result_index,
    input wire [W-1:0] result_data
);
    timeunit 1ns;
    timeprecision 1ps;
    wire         known = opcode inside {16'h0F67, 16'h0FFC, 16'h0FFE,
        16'h0FEC, 16'h0FED, 16'h0FDC, 16'h0FDD, 16'h0FFD, 16'h0FDB,
        16'h0FDF, 16'h0F74, 16'h0F75, 16'h0F76, 16'h0F64};
    wire [W-1:0] srcv = modrm_mode == 2'b11 ? src_vector_reg : mem_operand;
    reg  [W-1:0] d_q;
    reg  [W-1:0] s_q;
    // operands of the last cycle, for the lane checks
    always @(posedge sys_clk) begin
        d_q <= dest_vector_reg;
        s_q <= srcv;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_take(op);
        issue_valid && opcode == op;
    endsequence
    AST_LATENCY: assert property (issue_valid && known |=>
        result_valid && !result_illegal) else $error("no result");
    AST_THROUGHPUT: assert property ((issue_valid && known)[*2] |=>
        result_valid && $past(result_valid)) else $error("gap in results");
    AST_IDLE: assert property (!issue_valid |=>
        !result_valid && !result_illegal && $stable(result_data))
        else $error("output moved while idle");
    AST_ILLEGAL: assert property (issue_valid && !known |=>
        result_illegal && !result_valid && result_data == '0)
        else $error("unknown opcode not flagged");
    AST_INDEX: assert property (issue_valid |=>
        result_index == $past(dest_index)) else $error("index lost");
    AST_AND: assert property (s_take(16'h0FDB) |=>
        result_data == (d_q & s_q)) else $error("and result");
    AST_ANDN: assert property (s_take(16'h0FDF) |=>
        result_data == (~d_q & s_q)) else $error("and-not result");
    AST_ADD_D: assert property (s_take(16'h0FFE) |=>
        result_data == {d_q[63:32] + s_q[63:32], d_q[31:0] + s_q[31:0]})
        else $error("dword sum");
    AST_CEQ_D: assert property (s_take(16'h0F76) |=>
        result_data == {{32{d_q[63:32] == s_q[63:32]}},
        {32{d_q[31:0] == s_q[31:0]}}}) else $error("dword compare");
endmodule
////////////////////////////////////////////////////////////////////////////
bind psa_simd_unit psa_simd_unit_asserts #(.W(W)) u_chk (
    .sys_clk(sys_clk), .rst_n(rst_n), .issue_valid(issue_valid),
    .opcode(opcode), .modrm_mode(modrm_mode), .dest_index(dest_index),
    .dest_vector_reg(dest_vector_reg), .src_vector_reg(src_vector_reg),
    .mem_operand(mem_operand), .result_valid(result_valid),
    .result_illegal(result_illegal), .result_index(result_index),
    .result_data(result_data));

/* dv/psa_issue_model.sv */
module psa_issue_model (
    // clock
    input wire          sys_clk,
    // issue
    output logic        issue_valid,
    output logic [15:0] opcode,
    output logic [1:0]  modrm_mode,
    output logic [2:0]  dest_index,
    // operands
    output logic [63:0] dest_vector_reg,
    output logic [63:0] src_vector_reg,
    output logic [63:0] mem_operand
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {issue_valid, opcode, modrm_mode, dest_index} = '0;
        {dest_vector_reg, src_vector_reg, mem_operand} = '0;
    end
    task issue(input logic [15:0] op, input logic [1:0] md,
               input logic [2:0] ix, input logic [63:0] a, b);
        @(posedge sys_clk);
        #1;
        issue_valid = 1'b1;
        opcode = op;
        modrm_mode = md;
        dest_index = ix;
        dest_vector_reg = a;
        // the source not selected carries garbage
        src_vector_reg = md == 2'b11 ? b : ~b;
        mem_operand = md == 2'b11 ? ~b : b;
    endtask
    task idle;
        @(posedge sys_clk);
        #1;
        issue_valid = 1'b0;
        opcode = ~opcode;
        dest_vector_reg = ~dest_vector_reg;
        src_vector_reg = ~src_vector_reg;
        mem_operand = ~mem_operand;
    endtask
endmodule

/* dv/tb_packed_simd_add_logic_compare.sv */
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
    err_total++; $display("wrong value at %0t: %h not %h", $time, g, e); \
    end end
module tb_packed_simd_add_logic_compare;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 0;
    logic        rst_n = 0;
    wire         issue_valid, result_valid, result_illegal;
    wire [15:0]  opcode;
    wire [1:0]   modrm_mode;
    wire [2:0]   dest_index, result_index;
    wire [63:0]  dvr, svr, mem, result_data;
    int          err_total = 0;
    int          comparisons = 0;
    int          cyc = 0;
    logic [15:0] ops [14] = '{16'h0F67, 16'h0FFC, 16'h0FFE, 16'h0FEC,
        16'h0FED, 16'h0FDC, 16'h0FDD, 16'h0FFD, 16'h0FDB, 16'h0FDF,
        16'h0F74, 16'h0F75, 16'h0F76, 16'h0F64};
    // hundreds: kind of lane operation, last two digits: lane width; codes 1 and 2 are AND and AND-NOT
    int          code [14] = '{516, 8, 32, 108, 116, 208, 216, 16, 1, 2,
        308, 316, 332, 408};
    always #10 sys_clk = ~sys_clk;
    psa_issue_model pm (.sys_clk(sys_clk), .issue_valid(issue_valid),
        .opcode(opcode), .modrm_mode(modrm_mode), .dest_index(dest_index),
        .dest_vector_reg(dvr), .src_vector_reg(svr), .mem_operand(mem));
    psa_simd_unit #(.W(64)) uut (.sys_clk(sys_clk), .rst_n(rst_n),
        .issue_valid(issue_valid), .opcode(opcode), .modrm_mode(modrm_mode),
        .dest_index(dest_index), .dest_vector_reg(dvr),
        .src_vector_reg(svr), .mem_operand(mem),
        .result_valid(result_valid), .result_illegal(result_illegal),
        .result_index(result_index), .result_data(result_data));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [63:0] expv(int c, logic [63:0] a, b);
        longint     x, y, z, m, hi, lo;
        int         n, k, i;
        logic [63:0] r;
        n = c % 100;
        k = c / 100;
        r = '0;
        if (c == 1) return a & b;
        if (c == 2) return ~a & b;
        m = (longint'(1) << n) - 1;
        for (i = 0; i < (k == 5 ? 8 : 64 / n); i++) begin
            x = ({b, a} >> (i * n)) & m;
            y = (b >> (i * n)) & m;
            if (k == 1 || k >= 4) begin
                x = x - ((x >> (n - 1)) << n);
                y = y - ((y >> (n - 1)) << n);
            end
            if (k == 5) y = 0;
            z = x + y;
            hi = k == 1 ? m >> 1 : (k == 5 ? 255 : m);
            lo = k == 1 ? -hi - 1 : 0;
            if (k == 1 || k == 2 || k == 5) z = z > hi ? hi : (z < lo ? lo : z);
            if (k == 3) z = x == y ? m : 0;
            if (k == 4) z = x > y ? m : 0;
            r = r | ((z & m) << (i * (k == 5 ? 8 : n)));
        end
        return r;
    endfunction
    task chk(int c, logic [63:0] a, b, logic [2:0] ix);
        `CHK(result_valid, 1'b1)
        `CHK(result_index, ix)
        `CHK(result_data, expv(c, a, b))
    endtask
    ////////////////////////////////////////////////////////////////////////
    task t_all_ops;
        logic [63:0] a, b, pa, pb;
        int          j, pc;
        for (j = 0; j < 28; j++) begin
            a = 64'h7F80_FF00_8001_7FFF;
            b = j < 14 ? 64'h0180_01FF_8000_7FFF : 64'h7F80_FF00_0001_7FFE;
            pm.issue(ops[j % 14], j < 14 ? 2'b11 : 2'(j % 3), 3'(j), a, b);
            if (j > 0) chk(pc, pa, pb, 3'(j - 1));
            pc = code[j % 14];
            pa = a;
            pb = b;
        end
        pm.idle();
        chk(pc, pa, pb, 3'd3);
    endtask
    task t_slow;
        pm.issue(16'h0FFD, 2'b01, 3'd5, 64'hFFFF_8000_7FFF_0001,
                 64'h0001_8000_0001_FFFF);
        repeat (4) begin
            pm.idle();
            `CHK(result_data, 64'h0000_0000_8000_0000)
        end
        `CHK(result_valid, 1'b0)
    endtask
    task t_illegal;
        pm.issue(16'h0F77, 2'b11, 3'd2, 64'h1234_5678_9ABC_DEF0, '1);
        pm.issue(16'h0FEC, 2'b11, 3'd1, 64'h7F80_0102_7F80_40C0,
                 64'h0180_FFFE_7F80_40C0);
        `CHK(result_illegal, 1'b1)
        `CHK(result_valid, 1'b0)
        `CHK(result_data, 64'h0000_0000_0000_0000)
        pm.issue(16'h0F67, 2'b00, 3'd7, 64'h0100_00FF_FF80_0005,
                 64'h7FFF_8000_0000_0080);
        `CHK(result_data, 64'h7F80_0000_7F80_7F80)
        pm.idle();
        `CHK(result_data, 64'hFF00_0080_FFFF_0005)
    endtask
    task print_verdict;
        $display("errors %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 1000) begin
            err_total++;
            print_verdict();
        end
    end
    initial begin
        repeat (16) @(posedge sys_clk);
        #1 rst_n = 1;
        `CHK(result_valid, 1'b0)
        t_all_ops();
        t_slow();
        t_illegal();
        print_verdict();
    end
endmodule
